// file: shared/pcc_pkg.sv
package pcc_pkg;
  // Channel count and bus geometry
  localparam int NCH    = 4;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int FREQ_W = 32;
  localparam int DUTY_W = 16;
  localparam int ACC_W  = 26;
  localparam int PROD_W = 36;

  // Clock rate and output limits
  localparam int CLK_PERIOD_NS = 40;
  localparam int CLK_HZ        = 1_000_000_000 / CLK_PERIOD_NS;
  localparam int FREQ_MIN_HZ   = 1;
  localparam int FREQ_MAX_HZ   = 100_000;
  localparam int DUTY_FULL     = 1000;

  // Register offsets (byte addresses)
  localparam logic [ADDR_W-1:0] OFS_STATUS  = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_REQUEST = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_PORTSEL = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_GPOUT   = 8'h0c;
  localparam logic [ADDR_W-1:0] OFS_FREQ0   = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_DUTY0   = 8'h20;

  // Field positions and reset values
  localparam int REQ_START_LSB  = 0;
  localparam int REQ_ENABLE_LSB = 4;
  localparam int PWM_Y_BASE     = 4;
  localparam int GPO_W          = 16;
  localparam logic [15:0] REQ_RESET   = 16'h0000;
  localparam logic [15:0] GPO_RESET   = 16'h0000;
  localparam logic [3:0]  SEL_RESET   = 4'h0;
  localparam logic [31:0] FREQ_RESET  = 32'h0000_0000;
  localparam logic [15:0] DUTY_RESET  = 16'h0000;

  typedef enum logic {PCC_IDLE, PCC_RUN} pcc_state_t;
endpackage : pcc_pkg

// file: shared/pcc_chan_if.sv
`timescale 1ns/1ps
interface pcc_chan_if;
  import pcc_pkg::*;
  logic              start_rise;
  logic              enable;
  logic [FREQ_W-1:0] freq_set;
  logic [DUTY_W-1:0] duty_set;
  logic              wave;
  logic              active;
  logic [FREQ_W-1:0] live_freq;
  logic [DUTY_W-1:0] live_duty;

  modport ctrl (output start_rise, enable, freq_set, duty_set,
                input  wave, active, live_freq, live_duty);
  modport chan (input  start_rise, enable, freq_set, duty_set,
                output wave, active, live_freq, live_duty);
endinterface : pcc_chan_if

// file: design/pcc_channel.sv
`timescale 1ns/1ps
module pcc_channel
  import pcc_pkg::*;
(
  input wire logic   clk,
  input wire logic   arst_n,
  pcc_chan_if.chan   ch
);
  pcc_state_t        state_reg;
  logic [FREQ_W-1:0] live_freq_reg, pend_freq_reg;
  logic [DUTY_W-1:0] live_duty_reg, pend_duty_reg;
  logic              pend_reg;
  logic [ACC_W-1:0]  acc_reg, acc_next, step;
  logic              wave_reg, valid, wrap, high_c, flat, apply;
  logic [DUTY_W-1:0] duty_c;

  // Phase accumulator and duty compare
  always_comb begin
    valid  = (live_freq_reg >= FREQ_W'(FREQ_MIN_HZ)) &&
             (live_freq_reg <= FREQ_W'(FREQ_MAX_HZ));
    duty_c = (live_duty_reg > DUTY_W'(DUTY_FULL)) ? DUTY_W'(DUTY_FULL) : live_duty_reg;
    step   = acc_reg + live_freq_reg[ACC_W-1:0];
    wrap   = step >= ACC_W'(CLK_HZ);
    acc_next = wrap ? step - ACC_W'(CLK_HZ) : step;
    high_c = (PROD_W'(acc_reg) * PROD_W'(DUTY_FULL)) <
             (PROD_W'(CLK_HZ) * PROD_W'(duty_c));
    flat   = (duty_c == '0) || (duty_c == DUTY_W'(DUTY_FULL));
    // Pending settings land at the pulse's falling edge, at the period wrap for flat duty, at once if the live frequency is invalid
    apply  = pend_reg && (!valid || (wave_reg && !high_c) || (wrap && flat));
  end

  // Run state, live and pending settings
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state_reg     <= PCC_IDLE;
      pend_reg      <= 1'b0;
      live_freq_reg <= '0;
      live_duty_reg <= '0;
      pend_freq_reg <= '0;
      pend_duty_reg <= '0;
    end else if (!ch.enable) begin
      state_reg <= PCC_IDLE;
      pend_reg  <= 1'b0;
    end else if (ch.start_rise) begin
      case (state_reg)
        PCC_IDLE: begin
          state_reg     <= PCC_RUN;
          live_freq_reg <= ch.freq_set;
          live_duty_reg <= ch.duty_set;
        end
        default: begin
          pend_reg      <= 1'b1;
          pend_freq_reg <= ch.freq_set;
          pend_duty_reg <= ch.duty_set;
        end
      endcase
    end else if (apply) begin
      live_freq_reg <= pend_freq_reg;
      live_duty_reg <= pend_duty_reg;
      pend_reg      <= 1'b0;
    end
  end

  // Accumulator runs only while output is live
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) acc_reg <= '0;
    else if (state_reg == PCC_RUN && ch.enable && valid) acc_reg <= acc_next;
    else acc_reg <= '0;
  end

  // Registered waveform, high part first
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) wave_reg <= 1'b0;
    else wave_reg <= (state_reg == PCC_RUN) && ch.enable && valid && high_c;
  end

  assign ch.wave      = wave_reg;
  assign ch.active    = (state_reg == PCC_RUN) && valid;
  assign ch.live_freq = live_freq_reg;
  assign ch.live_duty = live_duty_reg;
endmodule : pcc_channel

// file: design/pcc_controller.sv
`timescale 1ns/1ps
// How it works
// - Y4..Y7 carry channels 0..3 when selected
// - Status bit shows each channel output on
// - 32-bit frequency word per channel, hertz
// - 16-bit duty word, tenth-percent steps
// - Start request rising edge starts output
// - Enable request bit gates channel output
// - Start edge needs enable already set
// - Dropping enable stops the channel
// - Frequency captured on start request edge
// - New frequency applied at pulse fall, or at period wrap for flat duty
// - Duty captured on start request edge
// - New duty applied at pulse fall, or at period wrap for flat duty
// - Four independent channels
// - Valid frequency one hertz to 100 kHz
module pcc_controller
  import pcc_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              arst_n,
  input  wire logic [ADDR_W-1:0] addr,
  input  wire logic [DATA_W-1:0] wdata,
  input  wire logic              wr_en,
  input  wire logic              rd_en,
  output logic      [DATA_W-1:0] rdata,
  output logic      [GPO_W-1:0]  y_out
);

  // Channel slot decode, shared by writes and reads
  function automatic logic slot_hit(input logic [ADDR_W-1:0] a,
                                    input logic [ADDR_W-1:0] base);
    slot_hit = (a[ADDR_W-1:4] == base[ADDR_W-1:4]) && (a[1:0] == 2'b00);
  endfunction : slot_hit

  logic [15:0]       req_reg;
  logic [3:0]        sel_reg;
  logic [GPO_W-1:0]  gpo_reg;
  logic [FREQ_W-1:0] freq_reg [NCH];
  logic [DUTY_W-1:0] duty_reg [NCH];
  logic [DATA_W-1:0] rdata_reg, rdata_next;
  logic [GPO_W-1:0]  y_reg, y_next;
  logic              wr_req, wr_freq, wr_duty;
  logic [1:0]        slot;
  logic [NCH-1:0]    start_rise, enable, wave, active;
  logic [FREQ_W-1:0] live_freq [NCH];
  logic [DUTY_W-1:0] live_duty [NCH];

  pcc_chan_if chan_bus [NCH] ();

  // Write decode
  assign slot    = addr[3:2];
  assign wr_req  = wr_en && (addr == OFS_REQUEST);
  assign wr_freq = wr_en && slot_hit(addr, OFS_FREQ0);
  assign wr_duty = wr_en && slot_hit(addr, OFS_DUTY0);

  // Request word: start and enable bits
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) req_reg <= REQ_RESET;
    else if (wr_req) req_reg <= wdata[15:0];
  end

  // Port function select and general outputs
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sel_reg <= SEL_RESET;
      gpo_reg <= GPO_RESET;
    end else if (wr_en && addr == OFS_PORTSEL) begin
      sel_reg <= wdata[3:0];
    end else if (wr_en && addr == OFS_GPOUT) begin
      gpo_reg <= wdata[GPO_W-1:0];
    end
  end

  // Setting words, one slot per channel
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      for (int i = 0; i < NCH; i++) begin
        freq_reg[i] <= FREQ_RESET;
        duty_reg[i] <= DUTY_RESET;
      end
    end else begin
      if (wr_freq) freq_reg[slot] <= wdata;
      if (wr_duty) duty_reg[slot] <= wdata[DUTY_W-1:0];
    end
  end

  // Channel engines
  for (genvar i = 0; i < NCH; i++) begin : g_ch
    // Edge is seen on the write that sets the bit
    assign start_rise[i] = wr_req && wdata[REQ_START_LSB+i] &&
                           !req_reg[REQ_START_LSB+i];
    // Old enable value: it must be set beforehand
    assign enable[i] = req_reg[REQ_ENABLE_LSB+i];

    assign chan_bus[i].start_rise = start_rise[i];
    assign chan_bus[i].enable     = enable[i];
    assign chan_bus[i].freq_set   = freq_reg[i];
    assign chan_bus[i].duty_set   = duty_reg[i];
    assign wave[i]      = chan_bus[i].wave;
    assign active[i]    = chan_bus[i].active;
    assign live_freq[i] = chan_bus[i].live_freq;
    assign live_duty[i] = chan_bus[i].live_duty;

    pcc_channel u_chan (
      .clk    (clk),
      .arst_n (arst_n),
      .ch     (chan_bus[i])
    );
  end

  // Output port mux, PWM over Y4..Y7 when selected
  always_comb begin
    y_next = gpo_reg;
    for (int i = 0; i < NCH; i++) begin
      if (sel_reg[i]) y_next[PWM_Y_BASE+i] = wave[i];
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) y_reg <= GPO_RESET;
    else y_reg <= y_next;
  end

  // Read mux, unmapped addresses read zero
  always_comb begin
    rdata_next = '0;
    if (addr == OFS_STATUS) rdata_next[NCH-1:0] = active;
    else if (addr == OFS_REQUEST) rdata_next[15:0] = req_reg;
    else if (addr == OFS_PORTSEL) rdata_next[3:0] = sel_reg;
    else if (addr == OFS_GPOUT) rdata_next[GPO_W-1:0] = gpo_reg;
    else if (slot_hit(addr, OFS_FREQ0)) rdata_next = freq_reg[slot];
    else if (slot_hit(addr, OFS_DUTY0)) rdata_next[DUTY_W-1:0] = duty_reg[slot];
  end

  // Read data holds only in the cycle after the strobe
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) rdata_reg <= '0;
    else if (rd_en) rdata_reg <= rdata_next;
    else rdata_reg <= '0;
  end

  assign rdata = rdata_reg;
  assign y_out = y_reg;

  // Checks, one clock domain
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  for (genvar i = 0; i < NCH; i++) begin : g_chk
    // Selected port follows the channel waveform
    AST_Y_FOLLOWS: assert property (
      sel_reg[i] |=> y_out[PWM_Y_BASE+i] == $past(wave[i])
    ) else $error("PWM port does not follow channel");

    // Status word reflects channel state
    AST_STATUS_READ: assert property (
      rd_en && addr == OFS_STATUS |=> rdata[i] == $past(active[i])
    ) else $error("status bit does not match channel state");

    // Start edge with enable set starts a valid channel
    AST_START_RUN: assert property (
      start_rise[i] && enable[i] && g_ch[i].u_chan.state_reg == PCC_IDLE &&
      freq_reg[i] >= FREQ_W'(FREQ_MIN_HZ) &&
      freq_reg[i] <= FREQ_W'(FREQ_MAX_HZ)
      |=> active[i]
    ) else $error("start edge did not start channel");

    // Start edge without enable is ignored
    AST_START_NEEDS_EN: assert property (
      start_rise[i] && !enable[i] && !active[i] |=> !active[i]
    ) else $error("start without enable started output");

    // Enable low forces output and status off
    AST_EN_STOPS: assert property (
      !enable[i] |=> !active[i] ##0 !wave[i] ##1 !wave[i] || enable[i]
    ) else $error("output continues without enable");

    // Idle start copies the setting words
    AST_CAPTURE: assert property (
      start_rise[i] && enable[i] && g_ch[i].u_chan.state_reg == PCC_IDLE
      |=> live_freq[i] == $past(freq_reg[i]) &&
          live_duty[i] == $past(duty_reg[i])
    ) else $error("settings not captured at start edge");

    // No change of settings while a pulse stays high
    AST_HOLD_PULSE: assert property (
      wave[i] && live_duty[i] < DUTY_W'(DUTY_FULL) ##1 wave[i]
      |-> $stable(live_freq[i]) && $stable(live_duty[i])
    ) else $error("settings changed inside a pulse");

    // Setting words outside a start edge leave output alone
    AST_WRITE_NO_EFFECT: assert property (
      active[i] && !start_rise[i] && $past(!start_rise[i]) &&
      wave[i] && $past(wave[i]) && live_duty[i] < DUTY_W'(DUTY_FULL)
      |-> $stable(live_duty[i])
    ) else $error("duty changed without a start edge");

    // Zero duty stays low
    AST_DUTY_ZERO: assert property (
      active[i] && enable[i] && live_duty[i] == '0 |=> !wave[i]
    ) else $error("zero duty produced a pulse");

    // Full duty stays high
    AST_DUTY_FULL: assert property (
      active[i] && enable[i] && live_duty[i] >= DUTY_W'(DUTY_FULL)
      |=> wave[i]
    ) else $error("full duty output went low");

    // Out of range frequency keeps channel dark
    AST_BAD_FREQ: assert property (
      live_freq[i] == '0 || live_freq[i] > FREQ_W'(FREQ_MAX_HZ)
      |-> !active[i] ##1 !wave[i] || live_freq[i] != $past(live_freq[i])
    ) else $error("invalid frequency drives output");

    // A half duty channel toggles within 260 cycles, just over one period of the top rate
    AST_TOGGLES: assert property (
      active[i] && enable[i] && live_freq[i] == FREQ_W'(FREQ_MAX_HZ) &&
      live_duty[i] == DUTY_W'(DUTY_FULL / 2) && !start_rise[i] &&
      wave[i]
      |-> ##[1:260] !wave[i] || !enable[i] || live_duty[i] != DUTY_W'(DUTY_FULL / 2)
    ) else $error("fastest channel did not toggle in time");

    // Frequency word lands in its own slot
    AST_FREQ_STORE: assert property (
      wr_freq && slot == 2'(i) |=> freq_reg[i] == $past(wdata)
    ) else $error("frequency word not stored");

    // Duty word lands in its own slot
    AST_DUTY_STORE: assert property (
      wr_duty && slot == 2'(i) |=> duty_reg[i] == $past(wdata[DUTY_W-1:0])
    ) else $error("duty word not stored");

    // Writes to other slots leave this channel's words alone
    AST_SLOT_APART: assert property (
      !(wr_freq && slot == 2'(i)) && !(wr_duty && slot == 2'(i))
      |=> $stable(freq_reg[i]) && $stable(duty_reg[i])
    ) else $error("setting word changed by another slot");

    // A stopped or dark channel drives no pulse
    AST_DARK_LOW: assert property (
      !active[i] |=> !wave[i]
    ) else $error("inactive channel produced a pulse");

    // Enable low takes the selected port low two cycles on
    AST_EN_GATES_PORT: assert property (
      sel_reg[i] && !enable[i] ##1 sel_reg[i] |=> !y_out[PWM_Y_BASE+i]
    ) else $error("disabled channel still drives its port");

    // A port that is not selected shows the general output bit
    AST_PORT_GPO: assert property (
      !sel_reg[i] |=> y_out[PWM_Y_BASE+i] == $past(gpo_reg[PWM_Y_BASE+i])
    ) else $error("unselected port does not show general output");

    // A running channel stays on while enabled and its setting holds
    AST_RUN_HOLDS: assert property (
      active[i] && enable[i] |=> active[i] || $changed(live_freq[i])
    ) else $error("running channel stopped on its own");

    // Without a start edge a dark channel stays dark
    AST_NO_EDGE_DARK: assert property (
      !active[i] && !start_rise[i] |=> !active[i] || $changed(live_freq[i])
    ) else $error("channel started without a start edge");

    // A start edge while running only queues the new words
    AST_QUEUE_ON_RUN: assert property (
      start_rise[i] && enable[i] && active[i]
      |=> $stable(live_freq[i]) && $stable(live_duty[i])
    ) else $error("running channel took new words at once");

    // New frequency lands only as a pulse ends
    AST_FREQ_AT_FALL: assert property (
      active[i] && $past(active[i]) && $changed(live_freq[i]) &&
      $past(live_duty[i]) < DUTY_W'(DUTY_FULL)
      |-> !wave[i]
    ) else $error("frequency changed inside a pulse");

    // New duty lands only as a pulse ends
    AST_DUTY_AT_FALL: assert property (
      active[i] && $past(active[i]) && $changed(live_duty[i]) &&
      $past(live_duty[i]) < DUTY_W'(DUTY_FULL)
      |-> !wave[i]
    ) else $error("duty changed inside a pulse");

    // Main scenarios
    COV_START: cover property (start_rise[i] && enable[i] ##1 active[i]);
    COV_FALL: cover property (wave[i] ##1 !wave[i] && active[i]);
    COV_STOP: cover property (active[i] ##1 !enable[i] ##1 !active[i]);
    COV_RESTART: cover property (active[i] && start_rise[i] && enable[i]);
    COV_APPLY: cover property (active[i] && $changed(live_duty[i]));
  end

  // Request word keeps what software wrote
  AST_REQ_STORE: assert property (
    wr_req |=> req_reg == $past(wdata[15:0])
  ) else $error("request word not stored");

  // Port select word keeps what software wrote
  AST_SEL_STORE: assert property (
    wr_en && addr == OFS_PORTSEL |=> sel_reg == $past(wdata[3:0])
  ) else $error("port select word not stored");

  // General output word keeps what software wrote
  AST_GPO_STORE: assert property (
    wr_en && addr == OFS_GPOUT |=> gpo_reg == $past(wdata[GPO_W-1:0])
  ) else $error("general output word not stored");

  // Ports outside the channel range always show general outputs
  AST_OTHER_PORTS: assert property (
    y_out[PWM_Y_BASE-1:0] == $past(gpo_reg[PWM_Y_BASE-1:0]) &&
    y_out[GPO_W-1:PWM_Y_BASE+NCH] == $past(gpo_reg[GPO_W-1:PWM_Y_BASE+NCH])
  ) else $error("shared port left the general output word");

  // Read data is zero outside the cycle after a read
  AST_RDATA_IDLE: assert property (
    !rd_en |=> rdata == '0
  ) else $error("read data stands without a read");

  // Status word carries nothing above the channel bits
  AST_STATUS_UPPER: assert property (
    rd_en && addr == OFS_STATUS |=> rdata[DATA_W-1:NCH] == '0
  ) else $error("status word upper bits not zero");

  // Request word reads back
  AST_READ_REQ: assert property (
    rd_en && addr == OFS_REQUEST |=> rdata == DATA_W'($past(req_reg))
  ) else $error("request word reads back wrong");

  // Setting words read back from their slots
  AST_READ_FREQ: assert property (
    rd_en && slot_hit(addr, OFS_FREQ0) |=> rdata == $past(freq_reg[slot])
  ) else $error("frequency word reads back wrong");

  AST_READ_DUTY: assert property (
    rd_en && slot_hit(addr, OFS_DUTY0) |=> rdata == DATA_W'($past(duty_reg[slot]))
  ) else $error("duty word reads back wrong");

endmodule : pcc_controller

// file: verif/pcc_controller_tb.sv
`timescale 1ns/1ps
module pcc_controller_tb
  import pcc_pkg::*;
;
  logic              clk;
  logic              arst_n;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wdata;
  logic              wr_en;
  logic              rd_en;
  logic [DATA_W-1:0] rdata;
  logic [GPO_W-1:0]  y_out;
  int                miscompares;
  int                checks;
  integer            seed;
  int                hi_cnt[NCH];
  int                per_cnt[NCH];
  int                last_hi[NCH];
  int                last_per[NCH];
  int                falls[NCH];
  logic [NCH-1:0]    prev_pwm;
  logic [DATA_W-1:0] rd_val;
  logic [DATA_W-1:0] rnd;

  pcc_controller i_dut (
    .clk    (clk),
    .arst_n (arst_n),
    .addr   (addr),
    .wdata  (wdata),
    .wr_en  (wr_en),
    .rd_en  (rd_en),
    .rdata  (rdata),
    .y_out  (y_out)
  );

  // Free-running clock
  initial begin
    clk = 1'b0;
    forever #(CLK_PERIOD_NS / 2) clk = ~clk;
  end

  // High time and period of each PWM port bit, sampled once settled
  always @(negedge clk) begin
    for (int i = 0; i < NCH; i++) begin
      if (y_out[PWM_Y_BASE+i] === 1'b1 && prev_pwm[i] === 1'b0) begin
        last_per[i] = per_cnt[i];
        per_cnt[i]  = 0;
      end
      if (y_out[PWM_Y_BASE+i] === 1'b0 && prev_pwm[i] === 1'b1) begin
        last_hi[i] = hi_cnt[i];
        hi_cnt[i]  = 0;
        falls[i]++;
      end
      if (y_out[PWM_Y_BASE+i] === 1'b1) hi_cnt[i]++;
      per_cnt[i]++;
      prev_pwm[i] = y_out[PWM_Y_BASE+i];
    end
  end

  function automatic logic [ADDR_W-1:0] fa(input int ch);
    return OFS_FREQ0 + ADDR_W'(4 * ch);
  endfunction : fa

  function automatic logic [ADDR_W-1:0] da(input int ch);
    return OFS_DUTY0 + ADDR_W'(4 * ch);
  endfunction : da

  function automatic logic [DATA_W-1:0] rq(input int ch, input logic e, input logic s);
    return (DATA_W'(e) << (REQ_ENABLE_LSB + ch)) | (DATA_W'(s) << (REQ_START_LSB + ch));
  endfunction : rq

  // Accumulator samples below the duty threshold
  function automatic int exp_hi(input longint f, input longint d);
    return int'((longint'(CLK_HZ) * d + DUTY_FULL * f - 1) / (DUTY_FULL * f));
  endfunction : exp_hi

  task automatic give_verdict();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : give_verdict

  task automatic chk(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
  endtask : wr

  // Read data stand only in the cycle after the strobe
  task automatic rd_chk(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
    @(posedge clk);
    addr  <= a;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    #1 rd_val = rdata;
    chk(rd_val, exp);
  endtask : rd_chk

  task automatic wait_falls(input int ch, input int n);
    int target;
    target = falls[ch] + n;
    for (int k = 0; k < 5000 && falls[ch] < target; k++) begin
      @(posedge clk);
      #1;
    end
    if (falls[ch] < target) begin
      chk(falls[ch], target);
      give_verdict();
    end
  endtask : wait_falls

  task automatic hold_lvl(input int ch, input logic lvl);
    logic ok;
    ok = 1'b1;
    for (int k = 0; k < 600; k++) begin
      @(posedge clk);
      #1;
      if (y_out[PWM_Y_BASE+ch] !== lvl) ok = 1'b0;
    end
    chk({31'h0, ok}, 32'h1);
  endtask : hold_lvl

  task automatic start_ch(input int ch, input logic [31:0] f, input logic [15:0] d);
    wr(fa(ch), f);
    wr(da(ch), {16'h0, d});
    wr(OFS_REQUEST, rq(ch, 1'b1, 1'b0));
    wr(OFS_REQUEST, rq(ch, 1'b1, 1'b1));
  endtask : start_ch

  // Main sequence
  initial begin
    int fs[4];
    logic [DATA_W-1:0] st[4];
    seed   = 32'h01ce33b5;
    fs     = '{0, 1, 100000, 100001};
    st     = '{32'h0, 32'h4, 32'h4, 32'h0};
    arst_n = 1'b0;
    addr   = '0;
    wdata  = '0;
    wr_en  = 1'b0;
    rd_en  = 1'b0;
    repeat (4) @(posedge clk);
    #1 chk({16'h0, y_out}, 32'h0);
    chk(rdata, 32'h0);
    @(posedge clk);
    arst_n <= 1'b1;
    // Reset values, unmapped and read-only places
    rd_chk(OFS_STATUS, 32'h0);
    rd_chk(OFS_REQUEST, 32'h0);
    for (int i = 0; i < NCH; i++) begin
      rd_chk(fa(i), 32'h0);
      rd_chk(da(i), 32'h0);
    end
    wr(8'hfc, 32'hffff_ffff);
    rd_chk(8'hfc, 32'h0);
    wr(OFS_STATUS, 32'hf);
    rd_chk(OFS_STATUS, 32'h0);
    wr(OFS_REQUEST, 32'hab00_ff00);
    rd_chk(OFS_REQUEST, 32'h0000_ff00);
    $display("test registers done");
    // Random setting words on every channel
    for (int i = 0; i < NCH; i++) begin
      rnd = $random(seed);
      wr(fa(i), rnd);
      rd_chk(fa(i), rnd);
      rnd = $random(seed);
      wr(da(i), rnd);
      rd_chk(da(i), {16'h0, rnd[15:0]});
    end
    $display("test settings done");
    // Start gating, waveform, stop, per channel
    for (int ch = 0; ch < NCH; ch++) begin
      wr(OFS_PORTSEL, 32'h1 << ch);
      wr(OFS_REQUEST, rq(ch, 1'b0, 1'b1));
      rd_chk(OFS_STATUS, 32'h0);
      wr(OFS_REQUEST, 32'h0);
      start_ch(ch, 100000, 500);
      rd_chk(OFS_STATUS, 32'h1 << ch);
      wait_falls(ch, 2);
      chk(last_hi[ch], exp_hi(100000, 500));
      chk(last_per[ch], CLK_HZ / 100000);
      wr(OFS_REQUEST, rq(ch, 1'b0, 1'b1));
      rd_chk(OFS_STATUS, 32'h0);
      hold_lvl(ch, 1'b0);
    end
    $display("test start stop done");
    // Frequency limits and duty extremes
    wr(OFS_PORTSEL, 32'hf);
    for (int i = 0; i < 4; i++) begin
      wr(OFS_REQUEST, 32'h0);
      start_ch(2, fs[i], 500);
      rd_chk(OFS_STATUS, st[i]);
    end
    hold_lvl(2, 1'b0);
    wr(OFS_REQUEST, 32'h0);
    for (int i = 0; i < 2; i++) begin
      wr(OFS_REQUEST, 32'h0);
      start_ch(3, 100000, (i == 0) ? 16'd0 : 16'(DUTY_FULL));
      rd_chk(OFS_STATUS, 32'h8);
      hold_lvl(3, i[0]);
    end
    $display("test limits done");
    // Settings wait for a start edge, then for the pulse fall
    wr(OFS_REQUEST, 32'h0);
    start_ch(0, 100000, 500);
    wait_falls(0, 1);
    wr(fa(0), 50000);
    wr(da(0), 200);
    wait_falls(0, 2);
    chk(last_hi[0], exp_hi(100000, 500));
    chk(last_per[0], CLK_HZ / 100000);
    for (int k = 0; k < 1000 && y_out[PWM_Y_BASE] !== 1'b1; k++) begin
      @(posedge clk);
      #1;
    end
    chk({31'h0, y_out[PWM_Y_BASE]}, 32'h1);
    wr(OFS_REQUEST, rq(0, 1'b1, 1'b0));
    wr(OFS_REQUEST, rq(0, 1'b1, 1'b1));
    wait_falls(0, 1);
    chk(last_hi[0], exp_hi(100000, 500));
    wait_falls(0, 2);
    chk(last_hi[0], exp_hi(50000, 200));
    chk(last_per[0], CLK_HZ / 50000);
    $display("test update timing done");
    // Ports fall back to the general output word
    wr(OFS_PORTSEL, 32'h0);
    wr(OFS_REQUEST, 32'h0);
    rnd = $random(seed);
    wr(OFS_GPOUT, rnd);
    repeat (3) @(posedge clk);
    #1 chk({16'h0, y_out}, {16'h0, rnd[15:0]});
    $display("test port select done");
    give_verdict();
  end
endmodule : pcc_controller_tb
